// [ofm_fault_monitor.sv]
`timescale 1ns/1ps
`include "ofm_params.svh"
// Function
// - regulator undervoltage latches its flag and forces all gates low
// - regulator recovery re-enables gates; flag stays until cleared
// - regulator monitor active from power-up, gates low until regulator good
// - regulator undervoltage mask disables flag and gate shutdown
// - regulator overvoltage only latches its flag
// - temperature warning only latches its status flag
// - supply overvoltage only latches its flag
// - supply undervoltage latches its flag and forces gates low
// - supply recovery re-enables gates; flag stays until cleared
// - each gate undervoltage monitored only while that gate is active
// - gate undervoltage only sets flags, which stay until cleared
// - any logic pin overvoltage latches the logic pin flag
// - logic pin overvoltage with stop-on-fault disables all gates
// - all pins back below threshold reactivates gates; flag stays
// - enable input directly gates all outputs
// - enable is direct by default; select bit turns on watchdog
// - first enable transition in watchdog mode activates gates, starts timer
// - missed toggle forces gates low and latches timeout flag
// - later enable transition reactivates gates; timeout flag stays
// - status bit 15 is common fault flag of status bits 0 to 2
// - every diagnostic here is maskable
module ofm_fault_monitor #(
	parameter int unsigned TMO_CYCLES = `OFM_TMO_TIME_NS / `OFM_CLK_PERIOD_NS,
	parameter int unsigned CNT_W      = 16
) (
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	input  wire logic             ce_i,
	input  wire ofm_pkg::ofm_cmp_t cmp_i,
	input  wire ofm_pkg::ofm_pin_t pin_i,
	input  wire ofm_pkg::ofm_bus_t bus_i,
	output logic [15:0]           rd_data_o,
	output logic [3:0]            gate_o
);

	// write hit on one register word
	function automatic logic ofm_wr_hit(
		input ofm_pkg::ofm_bus_t b,
		input logic [3:0]        off
	);
		ofm_wr_hit = b.wr && (b.addr == off);
	endfunction

	// sticky flag update, set wins over a write-one clear
	function automatic logic [15:0] ofm_sticky(
		input logic [15:0] old,
		input logic [15:0] set,
		input logic        clr,
		input logic [15:0] wd
	);
		logic [15:0] kill;
		kill = clr ? wd : 16'h0000;
		ofm_sticky = (old & ~kill) | set;
	endfunction

	localparam logic [CNT_W-1:0] TMO_LOAD = CNT_W'(TMO_CYCLES - 1);

	// synchroniser stages
	ofm_pkg::ofm_cmp_t cmp_m_q;
	ofm_pkg::ofm_cmp_t cmp_s_q;
	ofm_pkg::ofm_pin_t pin_m_q;
	ofm_pkg::ofm_pin_t pin_s_q;
	logic              en_p_q;

	// software registers
	logic [15:0] cfg_q;
	logic [15:0] mask_q;
	logic [15:0] diag0_q;
	logic [15:0] diag0_d;
	logic [15:0] diag1_q;
	logic [15:0] diag1_d;
	logic [15:0] diag2_q;
	logic [15:0] diag2_d;
	logic [15:0] stat_q;
	logic [15:0] stat_d;
	logic [15:0] rd_d;

	// watchdog
	ofm_pkg::ofm_wd_t wd_q;
	ofm_pkg::ofm_wd_t wd_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             wdsel_p_q;

	// live fault terms
	logic       reg_uv_act;
	logic       reg_ov_act;
	logic       sup_ov_act;
	logic       sup_uv_act;
	logic       temp_act;
	logic       pin_ov_act;
	logic [3:0] guv_act;
	logic       en_edge;
	logic       tmo_ev;
	logic       en_ok;
	logic       drive_ok;
	logic [3:0] gate_d;

	// comparator and pin synchronisers
	// two-flop synchroniser
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cmp_m_q <= `OFM_CMP_RST;
			cmp_s_q <= `OFM_CMP_RST;
		end else if (ce_i) begin
			cmp_m_q <= cmp_i;
			cmp_s_q <= cmp_m_q;
		end
	end

	// logic pin synchronisers and enable history
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			pin_m_q <= '0;
			pin_s_q <= '0;
			en_p_q  <= 1'b0;
		end else if (ce_i) begin
			pin_m_q <= pin_i;
			pin_s_q <= pin_m_q;
			en_p_q  <= pin_s_q.enable;
		end
	end

	// masked fault states
	// per-diagnostic masks
	assign reg_ov_act = cmp_s_q.vreg_ov & ~mask_q[`OFM_MSK_REG_OV];
	assign sup_ov_act = cmp_s_q.vbb_ov & ~mask_q[`OFM_MSK_SUP_OV];
	assign temp_act   = cmp_s_q.temp_warn & ~mask_q[`OFM_MSK_TEMP];
	assign reg_uv_act = cmp_s_q.vreg_uv & ~mask_q[`OFM_MSK_REG_UV];
	assign sup_uv_act = cmp_s_q.vbb_uv & ~mask_q[`OFM_MSK_SUP_UV];
	assign pin_ov_act = (|cmp_s_q.logic_ov) & ~mask_q[`OFM_MSK_PIN_OV];
	assign guv_act = cmp_s_q.gate_uv & gate_o & ~mask_q[`OFM_MSK_GUV +: 4];

	// enable transition
	assign en_edge = pin_s_q.enable ^ en_p_q;

	// configuration register
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cfg_q <= `OFM_CFG_RST;
		end else if (ce_i && ofm_wr_hit(bus_i, `OFM_ADR_CFG)) begin
			cfg_q <= {14'h0000, bus_i.wdata[1:0]};
		end
	end

	// mask register
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			mask_q <= `OFM_MASK_RST;
		end else if (ce_i && ofm_wr_hit(bus_i, `OFM_ADR_MASK)) begin
			mask_q <= {4'h0, bus_i.wdata[11:8], 1'b0, bus_i.wdata[6:0]};
		end
	end

	// watchdog next state and timer
	always_comb begin
		wd_d  = wd_q;
		cnt_d = cnt_q;
		tmo_ev = 1'b0;
		if (!cfg_q[`OFM_CFG_WDSEL] || !wdsel_p_q) begin
			// direct mode, or just entered watchdog mode
			wd_d  = ofm_pkg::OFM_WD_IDLE;
			cnt_d = TMO_LOAD;
		end else begin
			unique case (wd_q)
				ofm_pkg::OFM_WD_IDLE,
				ofm_pkg::OFM_WD_TIMEOUT: begin
					if (en_edge) begin
						wd_d  = ofm_pkg::OFM_WD_RUN;
						cnt_d = TMO_LOAD;
					end
				end
				ofm_pkg::OFM_WD_RUN: begin
					if (en_edge) begin
						cnt_d = TMO_LOAD;
					end else if (cnt_q == '0) begin
						wd_d   = ofm_pkg::OFM_WD_TIMEOUT;
						tmo_ev = ~mask_q[`OFM_MSK_TMO];
					end else begin
						cnt_d = cnt_q - 1'b1;
					end
				end
				default: begin
					wd_d = ofm_pkg::OFM_WD_IDLE;
				end
			endcase
		end
	end

	// watchdog state registers
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			wd_q    <= ofm_pkg::OFM_WD_IDLE;
			cnt_q     <= TMO_LOAD;
			wdsel_p_q <= 1'b0;
		end else if (ce_i) begin
			wd_q      <= wd_d;
			cnt_q     <= cnt_d;
			wdsel_p_q <= cfg_q[`OFM_CFG_WDSEL];
		end
	end

	// enable qualification
	// direct level unless watchdog selected
	assign en_ok = cfg_q[`OFM_CFG_WDSEL] ? (wd_q == ofm_pkg::OFM_WD_RUN) : pin_s_q.enable;

	// output gating from all shutdown sources
	// regulator undervoltage blocks
	assign drive_ok = ~reg_uv_act & ~sup_uv_act & ~(pin_ov_act & cfg_q[`OFM_CFG_STOP]) & en_ok;

	assign gate_d = drive_ok ? pin_s_q.phase : 4'h0;

	// gate drive outputs
	// recovery re-enables
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			gate_o <= 4'h0;
		end else if (ce_i) begin
			gate_o <= gate_d;
		end
	end

	// sticky flag next values
	always_comb begin
		diag0_d = ofm_sticky(diag0_q, {12'h000, guv_act},
			ofm_wr_hit(bus_i, `OFM_ADR_DIAG0), {12'h000, bus_i.wdata[3:0]});
		diag1_d = ofm_sticky(diag1_q, {14'h0000, reg_ov_act, reg_uv_act},
			ofm_wr_hit(bus_i, `OFM_ADR_DIAG1), {14'h0000, bus_i.wdata[1:0]});
		diag2_d = ofm_sticky(diag2_q, {14'h0000, sup_uv_act, sup_ov_act},
			ofm_wr_hit(bus_i, `OFM_ADR_DIAG2), {14'h0000, bus_i.wdata[1:0]});
		stat_d = ofm_sticky(stat_q, {13'h0000, temp_act, pin_ov_act, tmo_ev},
			ofm_wr_hit(bus_i, `OFM_ADR_STAT), {13'h0000, bus_i.wdata[2:0]});
		stat_d[`OFM_ST_COMMON] = |stat_d[2:0];
	end

	// sticky flag registers
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			diag0_q <= 16'h0000;
			diag1_q <= 16'h0000;
			diag2_q <= 16'h0000;
			stat_q  <= 16'h0000;
		end else if (ce_i) begin
			diag0_q <= diag0_d;
			diag1_q <= diag1_d;
			diag2_q <= diag2_d;
			stat_q  <= stat_d;
		end
	end

	// read multiplexer, unmapped words read zero
	always_comb begin
		unique case (bus_i.addr)
			`OFM_ADR_CFG:   rd_d = cfg_q;
			`OFM_ADR_MASK:  rd_d = mask_q;
			`OFM_ADR_DIAG0: rd_d = diag0_q;
			`OFM_ADR_DIAG1: rd_d = diag1_q;
			`OFM_ADR_DIAG2: rd_d = diag2_q;
			`OFM_ADR_STAT:  rd_d = stat_q;
			`OFM_ADR_LIVE:  rd_d = {wd_q, 2'b00, gate_o, guv_act,
				pin_ov_act, sup_uv_act, reg_ov_act, reg_uv_act};
			default:        rd_d = 16'h0000;
		endcase
	end

	// read data stands one cycle after the strobe only
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rd_data_o <= 16'h0000;
		end else if (ce_i) begin
			rd_data_o <= bus_i.rd ? rd_d : 16'h0000;
		end
	end

endmodule

// [ofm_params.svh]
`ifndef OFM_PARAMS_SVH
`define OFM_PARAMS_SVH

// register word offsets
`define OFM_ADR_CFG   4'h0
`define OFM_ADR_MASK  4'h1
`define OFM_ADR_DIAG0 4'h2
`define OFM_ADR_DIAG1 4'h3
`define OFM_ADR_DIAG2 4'h4
`define OFM_ADR_STAT  4'h5
`define OFM_ADR_LIVE  4'h6

// configuration bits
`define OFM_CFG_STOP  0
`define OFM_CFG_WDSEL 1

// mask bits
`define OFM_MSK_REG_UV 0
`define OFM_MSK_REG_OV 1
`define OFM_MSK_SUP_OV 2
`define OFM_MSK_SUP_UV 3
`define OFM_MSK_TEMP   4
`define OFM_MSK_PIN_OV 5
`define OFM_MSK_TMO    6
`define OFM_MSK_GUV    8

// flag bits in diag 1, diag 2 and status
`define OFM_D1_REG_UV 0
`define OFM_D1_REG_OV 1
`define OFM_D2_SUP_OV 0
`define OFM_D2_SUP_UV 1
`define OFM_ST_TMO    0
`define OFM_ST_PIN_OV 1
`define OFM_ST_TEMP   2
`define OFM_ST_COMMON 15

// reset values
`define OFM_CFG_RST  16'h0000
`define OFM_MASK_RST 16'h0000
`define OFM_CMP_RST  15'h4000

// timing
`define OFM_CLK_PERIOD_NS 8
`define OFM_TMO_TIME_NS   20000

`endif

// [ofm_pkg.sv]
package ofm_pkg;

	// qualified analog comparator indications
	typedef struct packed {
		logic       vreg_uv;
		logic       vreg_ov;
		logic       temp_warn;
		logic       vbb_ov;
		logic       vbb_uv;
		logic [3:0] gate_uv;
		logic [5:0] logic_ov;
	} ofm_cmp_t;

	// logic input pins
	typedef struct packed {
		logic       enable;
		logic [3:0] phase;
	} ofm_pin_t;

	// register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ofm_bus_t;

	// enable watchdog states
	typedef enum logic [1:0] {
		OFM_WD_IDLE    = 2'b00,
		OFM_WD_RUN     = 2'b01,
		OFM_WD_TIMEOUT = 2'b10
	} ofm_wd_t;

endpackage

// [ofm_checker.sv]
`timescale 1ns/1ps
`include "ofm_params.svh"
module ofm_checker #(
	parameter int unsigned TMO_CYCLES = 20
) (
	input wire logic              clock_i,
	input wire logic              nrst_i,
	input wire logic              ce_i,
	input wire ofm_pkg::ofm_cmp_t cmp_i,
	input wire ofm_pkg::ofm_pin_t pin_i,
	input wire ofm_pkg::ofm_bus_t bus_i,
	input wire logic [15:0]       rd_data_o,
	input wire logic [3:0]        gate_o
);
	logic [15:0] cfg_q;
	logic [15:0] msk_q;
	logic [7:0]  idle_q;
	logic        ok;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i || !ce_i);
	// shadow of config and mask writes
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cfg_q <= 16'h0000;
			msk_q <= 16'h0000;
		end else if (bus_i.wr && bus_i.addr == `OFM_ADR_CFG) begin
			cfg_q <= bus_i.wdata;
		end else if (bus_i.wr && bus_i.addr == `OFM_ADR_MASK) begin
			msk_q <= bus_i.wdata;
		end
	end
	// cycles since enable last moved in watchdog mode
	always_ff @(posedge clock_i) begin
		if (!nrst_i || !cfg_q[1] || pin_i.enable != $past(pin_i.enable)) begin
			idle_q <= 8'h00;
		end else if (idle_q != 8'hff) begin
			idle_q <= idle_q + 8'h01;
		end
	end
	// direct mode with nothing holding the gates off
	assign ok = pin_i.enable && !cmp_i.vreg_uv && !cmp_i.vbb_uv && !cfg_q[1]
		&& !(cfg_q[0] && |cmp_i.logic_ov);
	sequence s_calm;
		ok && !bus_i.wr ##1 !bus_i.wr;
	endsequence
	sequence s_rd_stat;
		bus_i.rd && bus_i.addr == `OFM_ADR_STAT;
	endsequence
	a_vreg_uv_off: assert property (cmp_i.vreg_uv && !msk_q[0] |-> ##3 gate_o == 4'h0)
		else $error("gates on in regulator undervoltage");
	a_vbb_uv_off: assert property (cmp_i.vbb_uv && !msk_q[3] |-> ##3 gate_o == 4'h0)
		else $error("gates on in supply undervoltage");
	a_pin_ov_stop: assert property (|cmp_i.logic_ov && cfg_q[0] && !msk_q[5]
		|-> ##3 gate_o == 4'h0) else $error("gates on in pin overvoltage");
	a_direct_follow: assert property (s_calm |=> ##1 gate_o == $past(pin_i.phase, 3))
		else $error("gates do not follow phase");
	a_wd_timeout: assert property (cfg_q[1] && idle_q > TMO_CYCLES + 8 |-> gate_o == 4'h0)
		else $error("gates on after enable timeout");
	a_wd_wait_first: assert property ($rose(cfg_q[1]) |-> ##3 (gate_o == 4'h0) [*3])
		else $error("gates on before first enable edge");
	a_ff_summary: assert property (s_rd_stat |=> rd_data_o[15] == |rd_data_o[2:0])
		else $error("common fault bit wrong");
	a_rd_idle: assert property (!$past(bus_i.rd) |-> rd_data_o == 16'h0000)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (bus_i.rd && bus_i.addr > `OFM_ADR_LIVE
		|=> rd_data_o == 16'h0000) else $error("unmapped read not zero");
endmodule
bind ofm_fault_monitor ofm_checker #(.TMO_CYCLES(TMO_CYCLES)) chk (.clock_i(clock_i),
	.nrst_i(nrst_i), .ce_i(ce_i), .cmp_i(cmp_i), .pin_i(pin_i), .bus_i(bus_i),
	.rd_data_o(rd_data_o), .gate_o(gate_o));

// [ofm_ctrl_model.sv]
`timescale 1ns/1ps
module ofm_ctrl_model (
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	input  wire logic        tog_i,
	input  wire logic [3:0]  phase_i,
	output ofm_pkg::ofm_pin_t pin_o
);
	logic en_q;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			en_q <= 1'b1;
		end else if (tog_i) begin
			en_q <= ~en_q;
		end
	end
	assign pin_o = {en_q, phase_i};
endmodule

// [operational_fault_monitor_bench.sv]
`timescale 1ns/1ps
`include "ofm_params.svh"
module operational_fault_monitor_bench;
	localparam int unsigned TMO = 20;
	typedef struct packed {
		logic [14:0] c;
		logic [3:0]  g;
		logic [3:0]  a;
		logic [15:0] d;
	} ofm_row_t;
	// comparator input, expected gates, flag word and value
	ofm_row_t rows [7] = '{
		'{15'h4000, 4'h0, `OFM_ADR_DIAG1, 16'h0001},
		'{15'h2000, 4'hf, `OFM_ADR_DIAG1, 16'h0002},
		'{15'h1000, 4'hf, `OFM_ADR_STAT, 16'h8004},
		'{15'h0800, 4'hf, `OFM_ADR_DIAG2, 16'h0001},
		'{15'h0400, 4'h0, `OFM_ADR_DIAG2, 16'h0002},
		'{15'h0140, 4'hf, `OFM_ADR_DIAG0, 16'h0005},
		'{15'h0021, 4'hf, `OFM_ADR_STAT, 16'h8002}};
	logic              clock_i = 1'b0;
	logic              nrst_i = 1'b0;
	logic              tog = 1'b0;
	logic              ce = 1'b1;
	logic [3:0]        phase = 4'hf;
	ofm_pkg::ofm_cmp_t cmp = 15'h4000;
	ofm_pkg::ofm_bus_t bus = 22'h000000;
	ofm_pkg::ofm_pin_t pin;
	logic [15:0]       rdat;
	logic [3:0]        gate;
	int                miscompares = 0;
	int                samples_checked = 0;
	always #4 clock_i = ~clock_i;
	ofm_fault_monitor #(.TMO_CYCLES(TMO), .CNT_W(16)) uut (.clock_i(clock_i),
		.nrst_i(nrst_i), .ce_i(ce), .cmp_i(cmp), .pin_i(pin), .bus_i(bus),
		.rd_data_o(rdat), .gate_o(gate));
	ofm_ctrl_model ctl (.clock_i(clock_i), .nrst_i(nrst_i), .tog_i(tog),
		.phase_i(phase), .pin_o(pin));
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cg(input logic [3:0] e);
		chk({12'h000, gate}, {12'h000, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wgate(input logic [3:0] e);
		for (int i = 0; i < 40 && gate !== e; i++) @(posedge clock_i);
		#1 cg(e);
		if (gate !== e) wrap_up();
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		bus <= {a, d, 1'b1, 1'b0};
		@(posedge clock_i);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock_i);
		bus <= {a, 16'h0000, 1'b0, 1'b1};
		@(posedge clock_i);
		bus.rd <= 1'b0;
		#1 chk(rdat, e);
	endtask
	task automatic tick();
		@(posedge clock_i);
		tog <= 1'b1;
		@(posedge clock_i);
		tog <= 1'b0;
	endtask
	// power-up, row table, then hand-written cases
	initial begin
		repeat (4) @(posedge clock_i);
		nrst_i <= 1'b1;
		cyc(8);
		cg(4'h0);
		@(posedge clock_i);
		cmp <= 15'h0000;
		wgate(4'hf);
		rd(`OFM_ADR_DIAG1, 16'h0001);
		wr(`OFM_ADR_DIAG1, 16'hffff);
		rd(`OFM_ADR_MASK, 16'h0000);
		rd(4'hf, 16'h0000);
		$display("power-up done");
		foreach (rows[k]) begin
			@(posedge clock_i);
			cmp <= rows[k].c;
			cyc(6);
			cg(rows[k].g);
			@(posedge clock_i);
			cmp <= 15'h0000;
			wgate(4'hf);
			rd(rows[k].a, rows[k].d);
			wr(rows[k].a, 16'hffff);
			rd(rows[k].a, 16'h0000);
			$display("row %0d done", k);
		end
		wr(`OFM_ADR_CFG, 16'h0001);
		@(posedge clock_i);
		cmp <= 15'h0001;
		cyc(6);
		cg(4'h0);
		@(posedge clock_i);
		cmp <= 15'h0000;
		wgate(4'hf);
		rd(`OFM_ADR_STAT, 16'h8002);
		wr(`OFM_ADR_STAT, 16'hffff);
		wr(`OFM_ADR_CFG, 16'h0000);
		$display("stop on fault done");
		wr(`OFM_ADR_MASK, 16'h0001);
		@(posedge clock_i);
		phase <= 4'h3;
		cyc(6);
		@(posedge clock_i);
		cmp <= 15'h43c0;
		cyc(6);
		cg(4'h3);
		@(posedge clock_i);
		cmp <= 15'h0000;
		cyc(6);
		@(posedge clock_i);
		phase <= 4'hf;
		rd(`OFM_ADR_DIAG1, 16'h0000);
		rd(`OFM_ADR_DIAG0, 16'h0003);
		wr(`OFM_ADR_DIAG0, 16'hffff);
		wr(`OFM_ADR_MASK, 16'h0000);
		$display("mask done");
		// clock enable low freezes the shutdown path
		@(posedge clock_i);
		ce <= 1'b0;
		cmp <= 15'h4000;
		cyc(6);
		cg(4'hf);
		@(posedge clock_i);
		ce <= 1'b1;
		wgate(4'h0);
		@(posedge clock_i);
		cmp <= 15'h0000;
		wgate(4'hf);
		wr(`OFM_ADR_DIAG1, 16'hffff);
		$display("clock enable done");
		wr(`OFM_ADR_CFG, 16'h0002);
		cyc(6);
		cg(4'h0);
		tick();
		wgate(4'hf);
		repeat (6) begin
			cyc(TMO / 2);
			tick();
		end
		cyc(1);
		cg(4'hf);
		cyc(TMO + 12);
		cg(4'h0);
		rd(`OFM_ADR_STAT, 16'h8001);
		tick();
		wgate(4'hf);
		rd(`OFM_ADR_STAT, 16'h8001);
		wr(`OFM_ADR_STAT, 16'hffff);
		wr(`OFM_ADR_CFG, 16'h0000);
		$display("watchdog done");
		wrap_up();
	end
endmodule
